/* gpr_pkg.sv */
// constants, types and register map of the drawing-engine register bank
// assumes a 32-bit AXI4-Lite host and a rendering datapath on the same clock
// Behaviour
// RULE1: decode 200h byte window starting at offset 8100h from graphics base address.
// RULE2: 8100h holds destination Y/X for block transfers, start Y/X for vectors.
// RULE3: 8104h holds width/height, or vector length and initial error.
// RULE4: 8108h holds source X/Y, or axial and diagonal error steps.
// RULE5: 810Ch holds two source expansion colours, used at 8 and 16 bpp.
// RULE6: four pattern colours: 0/1 at 8110h, 2/3 at 8114h, used for expansion.
// RULE7: 128 pattern bits from four words; word0 is 31:0, word3 is 127:96.
// RULE8: separate legacy write path control 8140h and read path control 8144h.
// RULE9: raster register 8200h governs how pixel data is combined toward memory.
// RULE10: write to 8204h starts a vector with currently loaded parameters.
// RULE11: write to 8208h starts a block transfer.
// RULE12: output bit indexes operation code by {pattern, source, destination} bits.
// RULE13: pattern mode field selects mono 01b, dither 10b, colour 11b.
// RULE14: software loads all parameters before writing a launch register.
package gpr_pkg;
	localparam logic [15:0] GPR_WIN_LO   = 16'h8100; // see RULE1
	localparam logic [15:0] GPR_WIN_SIZE = 16'h0200; // see RULE1
	localparam int          GPR_NREG     = 16;
	localparam logic [15:0] GPR_OFF_DEST   = 16'h8100;
	localparam logic [15:0] GPR_OFF_SIZE   = 16'h8104;
	localparam logic [15:0] GPR_OFF_SRC    = 16'h8108;
	localparam logic [15:0] GPR_OFF_SCOL   = 16'h810c;
	localparam logic [15:0] GPR_OFF_PCOL0  = 16'h8110;
	localparam logic [15:0] GPR_OFF_PCOL2  = 16'h8114;
	localparam logic [15:0] GPR_OFF_PAT0   = 16'h8120;
	localparam logic [15:0] GPR_OFF_PAT1   = 16'h8124;
	localparam logic [15:0] GPR_OFF_PAT2   = 16'h8128;
	localparam logic [15:0] GPR_OFF_PAT3   = 16'h812c;
	localparam logic [15:0] GPR_OFF_LWR    = 16'h8140;
	localparam logic [15:0] GPR_OFF_LRD    = 16'h8144;
	localparam logic [15:0] GPR_OFF_RASTER = 16'h8200;
	localparam logic [15:0] GPR_OFF_VEC    = 16'h8204;
	localparam logic [15:0] GPR_OFF_BLT    = 16'h8208;
	localparam logic [15:0] GPR_OFF_STAT   = 16'h82fc;
	// register indices in storage order
	localparam int GPR_I_DEST = 0;
	localparam int GPR_I_SIZE = 1;
	localparam int GPR_I_SRC  = 2;
	localparam int GPR_I_SCOL = 3;
	localparam int GPR_I_PC0  = 4;
	localparam int GPR_I_PC2  = 5;
	localparam int GPR_I_PAT0 = 6;
	localparam int GPR_I_LWR  = 10;
	localparam int GPR_I_LRD  = 11;
	localparam int GPR_I_RAST = 12;
	localparam int GPR_I_VEC  = 13;
	localparam int GPR_I_BLT  = 14;
	localparam int GPR_I_STAT = 15;
	localparam logic [15:0] GPR_OFFS [GPR_NREG] = '{
		GPR_OFF_DEST, GPR_OFF_SIZE, GPR_OFF_SRC, GPR_OFF_SCOL, GPR_OFF_PCOL0, GPR_OFF_PCOL2,
		GPR_OFF_PAT0, GPR_OFF_PAT1, GPR_OFF_PAT2, GPR_OFF_PAT3, GPR_OFF_LWR, GPR_OFF_LRD,
		GPR_OFF_RASTER, GPR_OFF_VEC, GPR_OFF_BLT, GPR_OFF_STAT};
	localparam logic [31:0] GPR_REG_RST  = 32'h0000_0000;
	// raster_combine_ctrl fields
	localparam int GPR_ROP_LSB     = 0;
	localparam int GPR_PMODE_LSB   = 8;
	localparam int GPR_PAT_TRN_BIT = 10;
	localparam int GPR_SRC_TRN_BIT = 11;
	localparam int GPR_BPP16_BIT   = 12;
	// status fields
	localparam int GPR_ST_VEC_BUSY = 0;
	localparam int GPR_ST_BLT_BUSY = 1;
	localparam logic [1:0] GPR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] GPR_RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		GPR_PM_SOLID  = 2'b00,
		GPR_PM_MONO   = 2'b01,
		GPR_PM_DITHER = 2'b10,
		GPR_PM_COLOR  = 2'b11
	} gpr_pmode_e;

	typedef struct packed {
		logic [31:0]  dest_start_coord;
		logic [31:0]  size_or_length_error;
		logic [31:0]  source_coord_or_error_steps;
		logic [31:0]  source_expand_colors;
		logic [63:0]  pattern_colors;
		logic [127:0] pattern_bits;
		logic [31:0]  raster_combine_ctrl;
		logic [31:0]  mode_word;
	} gpr_params_s;

	typedef struct packed {
		logic [31:0] write_path;
		logic [31:0] read_path;
	} gpr_legacy_s;
endpackage : gpr_pkg

/* gpr_rop.sv */
// bitwise raster combine of pattern, source and destination words
// assumes all inputs settle within one clock; purely combinational
`timescale 1ns/10ps
module gpr_rop #(
	parameter int W = 16
) (
	input  wire logic [7:0]   rop_i,
	input  wire logic [W-1:0] pat_i,
	input  wire logic [W-1:0] src_i,
	input  wire logic [W-1:0] dst_i,
	output logic      [W-1:0] out_o
);
	import gpr_pkg::*;
	for (genvar b = 0; b < W; b++) begin : g_bit
		assign out_o[b] = rop_i[{pat_i[b], src_i[b], dst_i[b]}]; // see RULE12
	end
endmodule : gpr_rop

/* gpr_pat.sv */
// pattern expansion: picks the pattern colour for one pixel of the 8x8 tile
// assumes pattern data is already justified to the screen origin
`timescale 1ns/10ps
module gpr_pat (
	input  wire logic [1:0]   mode_i,
	input  wire logic         bpp16_i,
	input  wire logic [127:0] bits_i,
	input  wire logic [63:0]  colors_i,
	input  wire logic [2:0]   row_i,
	input  wire logic [2:0]   col_i,
	output logic      [15:0]  color_o,
	output logic              clear_o
);
	import gpr_pkg::*;
	logic [6:0] mono_idx;
	logic [6:0] dlo_idx;
	logic [6:0] dhi_idx;
	logic [1:0] sel;

	// bit 7 of each row byte is the leftmost pixel
	assign mono_idx = {1'b0, row_i, 3'h7 - col_i};
	assign dlo_idx  = {row_i, 1'b0, 3'h7 - col_i};
	assign dhi_idx  = {row_i, 1'b1, 3'h7 - col_i};

	always_comb begin
		sel     = 2'h0;
		color_o = 16'h0000;
		unique case (gpr_pmode_e'(mode_i)) // see RULE13
			GPR_PM_SOLID: sel = 2'h0;
			GPR_PM_MONO: sel = {1'b0, bits_i[mono_idx]};
			GPR_PM_DITHER: sel = {bits_i[dhi_idx], bits_i[dlo_idx]};
			GPR_PM_COLOR: sel = 2'h0;
		endcase
		clear_o = (sel == 2'h0);
		color_o = colors_i[{sel, 4'h0} +: 16]; // see RULE6
		if (mode_i == GPR_PM_COLOR) begin
			clear_o = 1'b0;
			if (bpp16_i) begin
				color_o = bits_i[{col_i, 4'h0} +: 16];
			end else begin
				color_o = {8'h00, bits_i[{1'b0, col_i, 3'h0} +: 8]};
			end
		end
	end
endmodule : gpr_pat

/* gpr_bank.sv */
// drawing-engine register bank with AXI4-Lite slave, launch pulses and pixel combine
// assumes host and rendering datapath share clock_i; datapath reports end of work
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
module gpr_bank #(
	parameter logic [31:0] GFX_BASE = 32'h0000_0000
) (
	input  wire logic                 clock_i,
	input  wire logic                 nrst_i,
	// AXI4-Lite slave
	input  wire logic [31:0]          s_axi_awaddr_i,
	input  wire logic                 s_axi_awvalid_i,
	output logic                      s_axi_awready_o,
	input  wire logic [31:0]          s_axi_wdata_i,
	input  wire logic [3:0]           s_axi_wstrb_i,
	input  wire logic                 s_axi_wvalid_i,
	output logic                      s_axi_wready_o,
	output logic [1:0]                s_axi_bresp_o,
	output logic                      s_axi_bvalid_o,
	input  wire logic                 s_axi_bready_i,
	input  wire logic [31:0]          s_axi_araddr_i,
	input  wire logic                 s_axi_arvalid_i,
	output logic                      s_axi_arready_o,
	output logic [31:0]               s_axi_rdata_o,
	output logic [1:0]                s_axi_rresp_o,
	output logic                      s_axi_rvalid_o,
	input  wire logic                 s_axi_rready_i,
	// rendering datapath
	output gpr_pkg::gpr_params_s      params_o,
	output gpr_pkg::gpr_legacy_s      legacy_o,
	output logic                      line_draw_start_o,
	output logic                      block_copy_start_o,
	input  wire logic                 line_draw_done_i,
	input  wire logic                 block_copy_done_i,
	input  wire logic                 pix_valid_i,
	input  wire logic [2:0]           pix_row_i,
	input  wire logic [2:0]           pix_col_i,
	input  wire logic                 pix_src_bit_i,
	input  wire logic [15:0]          pix_dst_i,
	output logic                      pix_valid_o,
	output logic [15:0]               pix_color_o,
	output logic                      pix_draw_o
);
	import gpr_pkg::*;

	typedef enum logic {
		GPR_RD_IDLE = 1'b0,
		GPR_RD_RESP = 1'b1
	} gpr_rd_e;

	logic [31:0]      regs_q [GPR_NREG];
	logic             aw_held_q;
	logic             w_held_q;
	logic [31:0]      awaddr_q;
	logic [31:0]      wdata_q;
	logic [3:0]       wstrb_q;
	logic             bvalid_q;
	logic [1:0]       bresp_q;
	gpr_rd_e          rd_q;
	logic [31:0]      rdata_q;
	logic [1:0]       rresp_q;
	logic             do_write;
	logic [15:0]      wr_off;
	logic             wr_in_win;
	logic [GPR_NREG-1:0] wr_hit;
	logic [15:0]      rd_off;
	logic             rd_in_win;
	logic [31:0]      rd_word;
	logic             vec_start_q;
	logic             blt_start_q;
	logic             vec_busy_q;
	logic             blt_busy_q;
	gpr_params_s      params_q;
	logic [31:0]      raster;
	logic [15:0]      pat_color;
	logic             pat_clear;
	logic [15:0]      src_color;
	logic [15:0]      rop_out;
	logic             pv_q;
	logic [15:0]      pcol_q;
	logic             pdraw_q;
	logic [31:0]      status_word;
	logic             pat_skip;
	logic             src_skip;
	logic [15:0]      pix_color_d;

	// window decode: offsets are relative to the graphics base address
	function automatic logic win_hit(input logic [15:0] off, input logic [31:0] addr);
		logic [31:0] rel;
		rel = addr - GFX_BASE;
		win_hit = (rel[31:16] == 16'h0000) && (off >= GPR_WIN_LO)
			&& (off < GPR_WIN_LO + GPR_WIN_SIZE); // see RULE1
	endfunction : win_hit

	// low address bits are dropped: every register is one aligned word
	function automatic logic [15:0] rel_off(input logic [31:0] addr);
		logic [31:0] rel;
		rel = addr - GFX_BASE;
		rel_off = {rel[15:2], 2'b00};
	endfunction : rel_off

	// write channel: address and data may arrive in either order
	// a write outside the window is answered DECERR and stores nothing
	assign s_axi_awready_o = !aw_held_q && !bvalid_q;
	assign s_axi_wready_o  = !w_held_q && !bvalid_q;
	assign do_write        = aw_held_q && w_held_q && !bvalid_q;
	assign wr_off          = rel_off(awaddr_q);
	assign wr_in_win       = win_hit(wr_off, awaddr_q);

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= 32'h0000_0000;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w_held_q <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata_i;
			wstrb_q  <= s_axi_wstrb_i;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bvalid_q <= 1'b0;
			bresp_q  <= GPR_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_in_win ? GPR_RESP_OKAY : GPR_RESP_DECERR;
		end else if (s_axi_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o  = bresp_q;

	// status is rebuilt from the busy flags; a write to it is answered but dropped
	always_comb begin
		status_word                  = 32'h0000_0000;
		status_word[GPR_ST_VEC_BUSY] = vec_busy_q;
		status_word[GPR_ST_BLT_BUSY] = blt_busy_q;
	end

	// storage: one word per register, byte strobes honoured; status is read-only
	for (genvar k = 0; k < GPR_NREG; k++) begin : g_reg
		assign wr_hit[k] = do_write && wr_in_win && (wr_off == GPR_OFFS[k]);
		if (k == GPR_I_STAT) begin : g_ro
			assign regs_q[k] = status_word;
		end else begin : g_rw
			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					regs_q[k] <= GPR_REG_RST;
				end else if (wr_hit[k]) begin // see RULE2
					for (int b = 0; b < 4; b++) begin
						if (wstrb_q[b]) begin
							regs_q[k][8*b +: 8] <= wdata_q[8*b +: 8];
						end
					end
				end
			end
		end
	end

	// launch pulses: any write to a launch register starts the engine, whatever the
	// strobes; the stored word lands on the same edge, so the copy below sees it
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vec_start_q <= 1'b0;
		end else begin
			vec_start_q <= wr_hit[GPR_I_VEC]; // see RULE10
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			blt_start_q <= 1'b0;
		end else begin
			blt_start_q <= wr_hit[GPR_I_BLT]; // see RULE11
		end
	end

	assign line_draw_start_o  = vec_start_q;
	assign block_copy_start_o = blt_start_q;

	// busy flags: a new launch in the cycle of a done wins over the clear
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vec_busy_q <= 1'b0;
		end else if (vec_start_q) begin
			vec_busy_q <= 1'b1;
		end else if (line_draw_done_i) begin
			vec_busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			blt_busy_q <= 1'b0;
		end else if (blt_start_q) begin
			blt_busy_q <= 1'b1;
		end else if (block_copy_done_i) begin
			blt_busy_q <= 1'b0;
		end
	end

	// working copy taken at launch, so software may reload the next operation
	// while the engine is still busy with this one
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			params_q <= '0;
		end else if (vec_start_q || blt_start_q) begin
			params_q.dest_start_coord            <= regs_q[GPR_I_DEST]; // see RULE2
			params_q.size_or_length_error        <= regs_q[GPR_I_SIZE]; // see RULE3
			params_q.source_coord_or_error_steps <= regs_q[GPR_I_SRC];  // see RULE4
			params_q.source_expand_colors        <= regs_q[GPR_I_SCOL]; // see RULE5
			params_q.pattern_colors <= {regs_q[GPR_I_PC2], regs_q[GPR_I_PC0]}; // see RULE6
			params_q.pattern_bits   <= {regs_q[GPR_I_PAT0+3], regs_q[GPR_I_PAT0+2],
				regs_q[GPR_I_PAT0+1], regs_q[GPR_I_PAT0]}; // see RULE7
			params_q.raster_combine_ctrl <= regs_q[GPR_I_RAST]; // see RULE9
			// mode_word holds the stored word of the launch register that started it
			params_q.mode_word <= vec_start_q ? regs_q[GPR_I_VEC] : regs_q[GPR_I_BLT];
		end
	end

	assign params_o = params_q;

	// legacy paths act at once, outside any launched operation
	assign legacy_o.write_path = regs_q[GPR_I_LWR]; // see RULE8
	assign legacy_o.read_path  = regs_q[GPR_I_LRD]; // see RULE8

	// read channel: one outstanding read, answer one cycle after address
	assign s_axi_arready_o = (rd_q == GPR_RD_IDLE);
	assign rd_off          = rel_off(s_axi_araddr_i);
	assign rd_in_win       = win_hit(rd_off, s_axi_araddr_i);

	always_comb begin
		rd_word = 32'h0000_0000;
		for (int k = 0; k < GPR_NREG; k++) begin
			if (rd_off == GPR_OFFS[k]) begin
				rd_word = regs_q[k];
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_q <= GPR_RD_IDLE;
		end else begin
			unique case (rd_q)
				GPR_RD_IDLE: begin
					if (s_axi_arvalid_i) begin
						rd_q <= GPR_RD_RESP;
					end
				end
				GPR_RD_RESP: begin
					if (s_axi_rready_i) begin
						rd_q <= GPR_RD_IDLE;
					end
				end
			endcase
		end
	end

	// data captured once per accepted read, so it stands unchanged until rready
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= 32'h0000_0000;
			rresp_q <= GPR_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rdata_q <= rd_in_win ? rd_word : 32'h0000_0000;
			rresp_q <= rd_in_win ? GPR_RESP_OKAY : GPR_RESP_DECERR;
		end
	end

	assign s_axi_rvalid_o = (rd_q == GPR_RD_RESP);
	assign s_axi_rdata_o  = rdata_q;
	assign s_axi_rresp_o  = rresp_q;

	// pixel combine on the launched copy of the raster settings
	assign raster = params_q.raster_combine_ctrl;

	gpr_pat u_pat (
		.mode_i   (raster[GPR_PMODE_LSB +: 2]),
		.bpp16_i  (raster[GPR_BPP16_BIT]),
		.bits_i   (params_q.pattern_bits),
		.colors_i (params_q.pattern_colors),
		.row_i    (pix_row_i),
		.col_i    (pix_col_i),
		.color_o  (pat_color),
		.clear_o  (pat_clear)
	);

	// source colour 0 low half, colour 1 high half; low byte only at 8 bpp
	assign src_color = pix_src_bit_i ? params_q.source_expand_colors[31:16]
		: params_q.source_expand_colors[15:0]; // see RULE5

	gpr_rop #(
		.W (16)
	) u_rop (
		.rop_i (raster[GPR_ROP_LSB +: 8]),
		.pat_i (pat_color),
		.src_i (src_color),
		.dst_i (pix_dst_i),
		.out_o (rop_out)
	);

	// pattern transparency only applies to mono patterns; solid, dither and colour pixels are never skipped by it
	assign pat_skip    = raster[GPR_PAT_TRN_BIT] && pat_clear
		&& (raster[GPR_PMODE_LSB +: 2] == GPR_PM_MONO); // see RULE13
	// source transparency drops pixels whose expanded source bit is clear
	assign src_skip    = raster[GPR_SRC_TRN_BIT] && !pix_src_bit_i;
	// 8 bpp keeps the upper byte at zero so the datapath can write either width
	assign pix_color_d = raster[GPR_BPP16_BIT] ? rop_out : {8'h00, rop_out[7:0]}; // see RULE9

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pv_q    <= 1'b0;
			pcol_q  <= 16'h0000;
			pdraw_q <= 1'b0;
		end else begin
			pv_q <= pix_valid_i;
			if (pix_valid_i) begin
				pcol_q  <= pix_color_d; // see RULE9
				// transparent pixels are skipped, not written
				pdraw_q <= !pat_skip && !src_skip;
			end
		end
	end

	assign pix_valid_o = pv_q;
	assign pix_color_o = pcol_q;
	assign pix_draw_o  = pdraw_q;
endmodule : gpr_bank

/* gpr_bank_monitor.sv */
// assertions for gpr_bank: bus handshakes, launch pulses and pixel timing
// assumes it is bound to gpr_bank and sees only its ports
`timescale 1ns/10ps
module gpr_bank_monitor import gpr_pkg::*; (
	input wire logic        clock_i,
	input wire logic        nrst_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        line_draw_start_o,
	input wire logic        block_copy_start_o,
	input wire logic        pix_valid_i,
	input wire logic        pix_valid_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
		s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
		else $error("write not answered in two cycles");
	a_bvalid_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response repeated");
	a_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write ready while response pending");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read not answered in one cycle");
	a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read ready while data pending");
	a_decerr_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == GPR_RESP_DECERR |->
		s_axi_rdata_o == 32'h0000_0000) else $error("refused read returned data");
	a_line_pulse: assert property (line_draw_start_o |=> !line_draw_start_o)
		else $error("line start pulse too long");
	a_copy_pulse: assert property (block_copy_start_o |=> !block_copy_start_o)
		else $error("copy start pulse too long");
	a_line_after_write: assert property ($rose(line_draw_start_o) |->
		s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("line start without a write");
	a_pix_latency: assert property (pix_valid_o == $past(pix_valid_i))
		else $error("pixel result not one cycle after request");
	c_line: cover property (line_draw_start_o);
	c_copy: cover property (block_copy_start_o);
	c_decerr: cover property (s_axi_bvalid_o && s_axi_bresp_o == GPR_RESP_DECERR);
endmodule : gpr_bank_monitor

bind gpr_bank gpr_bank_monitor u_mon (.*);

/* gpr_bank_test.sv */
// self-checking bench for gpr_bank with a register and pixel model
// assumes gpr_bank_monitor is bound to the design; bready and rready stay high
`timescale 1ns/10ps
module gpr_bank_test;
	import gpr_pkg::*;
	// nonzero base so that decode of the base itself is exercised
	localparam logic [31:0] B = 32'h0004_0000;
	logic clock_i = 0;
	logic nrst_i = 0;
	logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	gpr_params_s params_o;
	gpr_legacy_s legacy_o;
	logic line_draw_start_o, block_copy_start_o, line_draw_done_i, block_copy_done_i;
	logic pix_valid_i, pix_src_bit_i, pix_valid_o, pix_draw_o;
	logic [2:0] pix_row_i, pix_col_i;
	logic [15:0] pix_dst_i, pix_color_o;
	logic [31:0] mdl [GPR_NREG];
	logic [31:0] seed = 32'ha6157fb8;
	int error_cnt = 0, checked = 0, nld = 0, nbc = 0, evl = 0, ebl = 0;

	gpr_bank #(.GFX_BASE(B)) u_dut (.*);
	always #20 clock_i = ~clock_i;
	// launch pulses last one cycle, so count them as they pass
	always @(posedge clock_i) begin
		if (line_draw_start_o) nld++;
		if (block_copy_start_o) nbc++;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic stop_test();
		$display("compares %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test

	task automatic cmp(input logic [383:0] got, input logic [383:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
		int n;
		logic aw, w;
		aw = 1;
		w = 1;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_wstrb_i <= s;
		s_axi_awvalid_i <= 1;
		s_axi_wvalid_i <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_i);
			if (!aw && !w && s_axi_bvalid_o) break;
			if (s_axi_awready_o) begin aw = 0; s_axi_awvalid_i <= 0; end
			if (s_axi_wready_o) begin w = 0; s_axi_wvalid_i <= 0; end
		end
		if (n < 50) cmp(s_axi_bresp_o, er);
		else begin error_cnt++; stop_test(); end
	endtask : wr

	task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
		int n;
		logic ar;
		ar = 1;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_i);
			if (!ar && s_axi_rvalid_o) break;
			if (s_axi_arready_o) begin ar = 0; s_axi_arvalid_i <= 0; end
		end
		if (n < 50) begin cmp(s_axi_rdata_o, exp); cmp(s_axi_rresp_o, er); end
		else begin error_cnt++; stop_test(); end
	endtask : rd

	task automatic launch(input int idx, input logic [31:0] d);
		wr(B + GPR_OFFS[idx], d, 4'hf, GPR_RESP_OKAY);
		mdl[idx] = d;
		if (idx == GPR_I_VEC) evl++; else ebl++;
		repeat (3) @(posedge clock_i);
		cmp({nld, nbc}, {evl, ebl});
		cmp(params_o, {mdl[0], mdl[1], mdl[2], mdl[3], mdl[5], mdl[4], mdl[9], mdl[8],
			mdl[7], mdl[6], mdl[12], d});
		rd(B + GPR_OFF_STAT, (idx == GPR_I_VEC) ? 1 : 2, GPR_RESP_OKAY);
		line_draw_done_i <= (idx == GPR_I_VEC);
		block_copy_done_i <= (idx != GPR_I_VEC);
		@(posedge clock_i);
		line_draw_done_i <= 0;
		block_copy_done_i <= 0;
		rd(B + GPR_OFF_STAT, '0, GPR_RESP_OKAY);
	endtask : launch

	function automatic logic [16:0] pmod(input logic [2:0] r, c, input logic sb,
		input logic [15:0] dv);
		logic [127:0] pb;
		logic [31:0] rc;
		logic [15:0] pc, sc, o;
		logic b0, b1;
		pb = {mdl[9], mdl[8], mdl[7], mdl[6]};
		rc = mdl[GPR_I_RAST];
		b0 = (rc[9:8] == 2) ? pb[r*16+7-c] : pb[r*8+7-c];
		b1 = (rc[9:8] == 2) ? pb[r*16+15-c] : 1'b0;
		case (rc[9:8])
			0: pc = mdl[4][15:0];
			3: pc = rc[12] ? pb[16*c +: 16] : {8'h00, pb[8*c +: 8]};
			default: pc = 16'({mdl[5], mdl[4]} >> (16 * {b1, b0}));
		endcase
		sc = sb ? mdl[3][31:16] : mdl[3][15:0];
		for (int i = 0; i < 16; i++) o[i] = rc[{pc[i], sc[i], dv[i]}];
		if (!rc[12]) o[15:8] = 8'h00;
		return {!((rc[9:8] == 1 && rc[10] && !b0) || (rc[11] && !sb)), o};
	endfunction : pmod

	initial begin
		int i, k, m, p;
		logic [31:0] d, t;
		logic [16:0] e;
		{s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i, s_axi_awvalid_i, s_axi_wvalid_i} = '0;
		{s_axi_araddr_i, s_axi_arvalid_i, line_draw_done_i, block_copy_done_i} = '0;
		{pix_valid_i, pix_src_bit_i, pix_row_i, pix_col_i, pix_dst_i} = '0;
		s_axi_bready_i = 1;
		s_axi_rready_i = 1;
		foreach (mdl[j]) mdl[j] = '0;
		repeat (4) @(posedge clock_i);
		nrst_i <= 1;
		for (i = 0; i < GPR_NREG; i++) rd(B + GPR_OFFS[i], '0, GPR_RESP_OKAY);
		$display("reset values done");
		repeat (2) for (i = 0; i < GPR_I_VEC; i++) begin
			d = rnd();
			t = rnd();
			wr(B + GPR_OFFS[i], d, t[3:0], GPR_RESP_OKAY);
			for (k = 0; k < 4; k++) if (t[k]) mdl[i][8*k +: 8] = d[8*k +: 8];
		end
		// edges of the window and a hole inside it must not disturb stored values
		wr(B + 32'h80fc, rnd(), 4'hf, GPR_RESP_DECERR);
		wr(B + 32'h8300, rnd(), 4'hf, GPR_RESP_DECERR);
		wr(B + 32'h8118, rnd(), 4'hf, GPR_RESP_OKAY);
		rd(B + 32'h8118, '0, GPR_RESP_OKAY);
		rd(32'h8100, '0, GPR_RESP_DECERR);
		rd(B + 32'h8300, '0, GPR_RESP_DECERR);
		for (i = 0; i < GPR_I_SCOL; i++) begin
			rd(B + GPR_OFFS[i], mdl[i], GPR_RESP_OKAY);
		end
		for (i = GPR_I_SCOL; i < GPR_I_VEC; i++) begin
			rd(B + GPR_OFFS[i], mdl[i], GPR_RESP_OKAY);
		end
		cmp(legacy_o, {mdl[GPR_I_LWR], mdl[GPR_I_LRD]});
		$display("register access done");
		launch(GPR_I_VEC, rnd());
		$display("line launch done");
		for (m = 0; m < 8; m++) begin
			d = (rnd() & 32'h0000_0cff) | ((m & 4) << 10) | ((m & 3) << 8);
			wr(B + GPR_OFF_RASTER, d, 4'hf, GPR_RESP_OKAY);
			mdl[GPR_I_RAST] = d;
			launch(GPR_I_BLT, rnd());
			for (p = 0; p < 16; p++) begin
				d = rnd();
				pix_valid_i <= 1;
				pix_row_i <= d[2:0];
				pix_col_i <= d[5:3];
				pix_src_bit_i <= d[6];
				pix_dst_i <= d[31:16];
				e = pmod(d[2:0], d[5:3], d[6], d[31:16]);
				@(posedge clock_i);
				pix_valid_i <= 0;
				@(posedge clock_i);
				cmp(pix_valid_o, 1'b1);
				cmp(pix_color_o, e[15:0]);
				cmp(pix_draw_o, e[16]);
			end
			$display("pixel mode %0d done", m);
		end
		stop_test();
	end
endmodule : gpr_bank_test
